/* File: ppm_pkg.sv */
package ppm_pkg;
  // command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEP = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEP = 8'h03;
  // action select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  // byte select codes
  localparam logic [1:0] BS_LOW = 2'h0;
  localparam logic [1:0] BS_HIGH = 2'h1;
  localparam logic [1:0] BS_EXT = 2'h2;
  localparam logic [1:0] BS_FHI = 2'h3;
  // geometry
  localparam int FLASH_AW = 14;
  localparam int EEP_AW = 10;
  localparam int FPAGE_W = 6;
  localparam int EPAGE_W = 2;
  localparam int FLASH_WORDS = 16384;
  localparam int EEP_BYTES = 1024;
  localparam int FPAGE_WORDS = 64;
  localparam int SIG_COUNT = 3;
  // reset values
  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] FUSE_EX_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // lock bit positions
  localparam int LOCK_B1 = 0;
  localparam int LOCK_B2 = 1;
  localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;
  // signature bytes, values arbitrary
  localparam logic [7:0] SIG0 = 8'h5a;
  localparam logic [7:0] SIG1 = 8'h01;
  localparam logic [7:0] SIG2 = 8'h02;
  // timing at 100 MHz
  localparam int CLK_NS = 10;
  localparam int T_WRITE_US = 4;
  localparam int T_ERASE_US = 8;
  localparam int WRITE_CYC = T_WRITE_US * 1000 / CLK_NS;
  localparam int ERASE_CYC = T_ERASE_US * 1000 / CLK_NS;
  localparam int BUSY_W = 20;

  typedef enum logic [1:0] {
    PPM_IDLE = 2'b00,
    PPM_BUSY = 2'b01,
    PPM_CLEAR = 2'b11
  } ppm_state_t;

  typedef struct packed {
    logic [1:0] action;
    logic [1:0] bsel;
    logic clk_pin;
    logic latch_pin;
    logic wr_n;
    logic oe_n;
  } ppm_ctl_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] doe_n;
  } ppm_bus_t;
endpackage : ppm_pkg

/* File: ppm_edge.sv */
`timescale 1ns/100ps
// rising and falling pulse detect on a vector of pins
module ppm_edge #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_r;
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign rise[i] = pin[i] & ~prev_r[i];
    assign fall[i] = ~pin[i] & prev_r[i];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= pin;
    end
  end
endmodule : ppm_edge

/* File: ppm_port.sv */
`timescale 1ns/100ps
// How it works
// - action 10 plus clock pulse captures data bus as command
// - action 00 loads address byte: low, high or extended by byte select
// - action 01 loads data byte; first byte select picks low or high
// - latch pulse with first select high stores data word into page buffer
// - low address bits pick word in page, upper bits pick page
// - write strobe with select 00 programs the latched words of the page; busy output low
// - no-operation command ends page programming, clears write controls
// - command 10 hex selects flash writing, word by word into buffer
// - command 11 hex selects eeprom page writing
// - command 02 hex reads flash low or high byte by first select
// - command 03 hex reads addressed eeprom byte
// - command 40 hex writes fuses from data low byte; 0 programs
// - byte select at write strobe picks low, high or extended fuses
// - command 20 hex writes lock bits from data low byte
// - lock mode 3 blocks programming of boot lock bits
// - programmed lock bits cannot be erased by a write
// - command 04 hex reads fuse or lock byte chosen by byte select
// - command 08 hex reads signature byte chosen by low address
// - ready output 0 while busy, 1 when ready for a command
// - command and address persist across operations
// - command 80 hex performs chip erase, also clearing lock bits
module ppm_port
#(
  parameter int WRITE_CYCLES = ppm_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = ppm_pkg::ERASE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  // programming pins
  input wire ppm_pkg::ppm_ctl_t ctl,
  input wire logic [7:0] data_in,
  // data bus drive, enable low while driving
  output ppm_pkg::ppm_bus_t bus,
  // status
  output logic ready_busy_out
);
  import ppm_pkg::*;

  typedef struct packed {
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ex;
    logic [7:0] lock;
    logic wr_armed;
    logic erase_op;
    ppm_state_t state;
    logic [BUSY_W-1:0] cnt;
    logic rdy;
    logic [7:0] dout;
    logic [7:0] doe_n;
  } ppm_regs_t;

  logic [1:0] rst_sync_r;
  logic rst_n;
  ppm_regs_t s_r, s_nxt;
  logic [2:0] rise;

  // flash page buffer and arrays
  logic [15:0] fbuf [FPAGE_WORDS];
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ebuf [4];
  logic [7:0] eep_mem [EEP_BYTES];
  logic [FPAGE_WORDS-1:0] fbuf_vld_r;
  logic [3:0] ebuf_vld_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ppm_edge #(.W(3)) u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin({ctl.clk_pin, ctl.latch_pin, ~ctl.wr_n}),
    .rise(rise),
    .fall()
  );

  logic clk_pulse, latch_pulse, wr_pulse;
  assign clk_pulse = rise[2];
  assign latch_pulse = rise[1];
  assign wr_pulse = rise[0];

  logic [FLASH_AW-1:0] faddr;
  logic [EEP_AW-1:0] eaddr;
  logic [FPAGE_W-1:0] fword;
  logic [EPAGE_W-1:0] eword;
  assign faddr = s_r.addr[FLASH_AW-1:0];
  assign eaddr = s_r.addr[EEP_AW-1:0];
  assign fword = faddr[FPAGE_W-1:0];
  assign eword = eaddr[EPAGE_W-1:0];
  logic [FLASH_AW-FPAGE_W-1:0] fpage;
  logic [EEP_AW-EPAGE_W-1:0] epage;
  assign fpage = faddr[FLASH_AW-1:FPAGE_W];
  assign epage = eaddr[EEP_AW-1:EPAGE_W];

  logic lock_bit_one, lock_bit_two, mode3;
  assign lock_bit_one = s_r.lock[LOCK_B1];
  assign lock_bit_two = s_r.lock[LOCK_B2];
  // both basic lock bits programmed
  assign mode3 = ~lock_bit_one & ~lock_bit_two;

  logic start_write;
  assign start_write = wr_pulse && s_r.state == PPM_IDLE;

  always_comb begin
    s_nxt = s_r;
    // command, address, data loads
    if (clk_pulse && s_r.rdy) begin
      unique case (ctl.action)
        ACT_CMD: begin
          s_nxt.cmd = data_in;
          if (data_in == CMD_NOP) begin
            s_nxt.wr_armed = 1'b0;
          end else begin
            s_nxt.wr_armed = 1'b1;
          end
        end
        ACT_ADDR: begin
          unique case (ctl.bsel)
            BS_LOW: s_nxt.addr[7:0] = data_in;
            BS_HIGH: s_nxt.addr[15:8] = data_in;
            BS_EXT: s_nxt.addr[23:16] = data_in;
            BS_FHI: s_nxt.addr = s_r.addr;
          endcase
        end
        ACT_DATA: begin
          if (ctl.bsel[0]) begin
            s_nxt.dhi = data_in;
          end else begin
            s_nxt.dlo = data_in;
          end
        end
        default: s_nxt.cmd = s_r.cmd;
      endcase
    end
    // self-timed write sequencing
    unique case (s_r.state)
      PPM_IDLE: begin
        if (start_write && s_r.wr_armed) begin
          unique case (s_r.cmd)
            CMD_WR_FLASH, CMD_WR_EEP: begin
              if (ctl.bsel == BS_LOW) begin
                s_nxt.state = PPM_BUSY;
                s_nxt.cnt = BUSY_W'(WRITE_CYCLES - 1);
                s_nxt.rdy = 1'b0;
              end
            end
            CMD_WR_FUSE: begin
              // 0 programs, 1 erases
              unique case (ctl.bsel)
                BS_LOW: s_nxt.fuse_lo = s_r.dlo;
                BS_HIGH: s_nxt.fuse_hi = s_r.dlo;
                BS_EXT: s_nxt.fuse_ex = s_r.dlo;
                BS_FHI: s_nxt.fuse_lo = s_r.fuse_lo;
              endcase
              s_nxt.state = PPM_BUSY;
              s_nxt.cnt = BUSY_W'(WRITE_CYCLES - 1);
              s_nxt.rdy = 1'b0;
            end
            CMD_WR_LOCK: begin
              // only ever clears bits
              if (mode3) begin
                s_nxt.lock = s_r.lock & (s_r.dlo | LOCK_BOOT_MASK);
              end else begin
                s_nxt.lock = s_r.lock & s_r.dlo;
              end
              s_nxt.state = PPM_BUSY;
              s_nxt.cnt = BUSY_W'(WRITE_CYCLES - 1);
              s_nxt.rdy = 1'b0;
            end
            CMD_ERASE: begin
              s_nxt.erase_op = 1'b1;
              s_nxt.state = PPM_BUSY;
              s_nxt.cnt = BUSY_W'(ERASE_CYCLES - 1);
              s_nxt.rdy = 1'b0;
            end
            default: s_nxt.state = PPM_IDLE;
          endcase
        end
      end
      PPM_BUSY: begin
        if (s_r.cnt == '0) begin
          s_nxt.state = PPM_CLEAR;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      PPM_CLEAR: begin
        if (s_r.erase_op) begin
          s_nxt.lock = LOCK_RST;
        end
        s_nxt.erase_op = 1'b0;
        s_nxt.state = PPM_IDLE;
        s_nxt.rdy = 1'b1;
      end
      // unused code falls back to idle
      default: begin
        s_nxt.state = PPM_IDLE;
        s_nxt.rdy = 1'b1;
      end
    endcase
    // read path
    s_nxt.dout = s_r.dout;
    unique case (s_r.cmd)
      CMD_RD_FLASH: begin
        s_nxt.dout = ctl.bsel[0] ? flash_mem[faddr][15:8]
                                 : flash_mem[faddr][7:0];
      end
      CMD_RD_EEP: s_nxt.dout = eep_mem[eaddr];
      CMD_RD_FUSE: begin
        unique case (ctl.bsel)
          BS_LOW: s_nxt.dout = s_r.fuse_lo;
          BS_FHI: s_nxt.dout = s_r.fuse_hi;
          BS_EXT: s_nxt.dout = s_r.fuse_ex;
          BS_HIGH: s_nxt.dout = s_r.lock;
        endcase
      end
      CMD_RD_SIG: begin
        unique case (s_r.addr[7:0])
          8'h00: s_nxt.dout = SIG0;
          8'h01: s_nxt.dout = SIG1;
          8'h02: s_nxt.dout = SIG2;
          default: s_nxt.dout = 8'h00;
        endcase
      end
      default: s_nxt.dout = 8'h00;
    endcase
    // drive only while output enable low
    s_nxt.doe_n = ctl.oe_n ? 8'hff : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{cmd: CMD_NOP, addr: '0, dlo: 8'hff, dhi: 8'hff,
               fuse_lo: FUSE_LO_RST, fuse_hi: FUSE_HI_RST,
               fuse_ex: FUSE_EX_RST, lock: LOCK_RST, wr_armed: 1'b0,
               erase_op: 1'b0, state: PPM_IDLE, cnt: '0, rdy: 1'b1,
               dout: 8'h00, doe_n: 8'hff};
    end else begin
      s_r <= s_nxt;
    end
  end

  // page buffer fill and commit
  logic commit;
  assign commit = s_r.state == PPM_CLEAR && !s_r.erase_op;

  always_ff @(posedge clk) begin
    if (latch_pulse && ctl.bsel[0] && s_r.cmd == CMD_WR_FLASH) begin
      fbuf[fword] <= {s_r.dhi, s_r.dlo};
    end
    if (latch_pulse && ctl.bsel[0] && s_r.cmd == CMD_WR_EEP) begin
      ebuf[eword] <= s_r.dlo;
    end
    if (commit && s_r.cmd == CMD_WR_FLASH) begin
      for (int i = 0; i < FPAGE_WORDS; i++) begin
        if (fbuf_vld_r[i]) begin
          flash_mem[{fpage, FPAGE_W'(i)}] <= fbuf[i];
        end
      end
    end
    if (commit && s_r.cmd == CMD_WR_EEP) begin
      for (int i = 0; i < 4; i++) begin
        if (ebuf_vld_r[i]) begin
          eep_mem[{epage, EPAGE_W'(i)}] <= ebuf[i];
        end
      end
    end
    if (s_r.state == PPM_CLEAR && s_r.erase_op) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_mem[i] <= {ERASED_BYTE, ERASED_BYTE};
      end
      for (int i = 0; i < EEP_BYTES; i++) begin
        eep_mem[i] <= ERASED_BYTE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbuf_vld_r <= '0;
      ebuf_vld_r <= '0;
    end else begin
      if (commit || !s_r.wr_armed) begin
        fbuf_vld_r <= '0;
        ebuf_vld_r <= '0;
      end
      // a latch in the clearing cycle still counts: set wins
      if (latch_pulse && ctl.bsel[0]) begin
        if (s_r.cmd == CMD_WR_FLASH) begin
          fbuf_vld_r[fword] <= 1'b1;
        end
        if (s_r.cmd == CMD_WR_EEP) begin
          ebuf_vld_r[eword] <= 1'b1;
        end
      end
    end
  end

  assign bus.dout = s_r.dout;
  assign bus.doe_n = s_r.doe_n;
  assign ready_busy_out = s_r.rdy;
endmodule : ppm_port

/* File: ppm_port_monitor.sv */
`timescale 1ns/100ps
module ppm_port_monitor #(
  parameter int WRITE_CYCLES = 5,
  parameter int ERASE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire ppm_pkg::ppm_ctl_t ctl,
  input wire logic [7:0] data_in,
  input wire ppm_pkg::ppm_bus_t bus,
  input wire logic ready_busy_out
);
  import ppm_pkg::*;
  logic [7:0] cmd_r;
  logic [7:0] adr_r;
  logic pin_r;
  logic [15:0] low_r;
  logic wcmd;
  logic flw;
  logic [7:0] sig;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shadow of the loaded command and low address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= CMD_NOP;
      adr_r <= 8'h00;
      pin_r <= 1'b0;
      low_r <= '0;
    end else begin
      pin_r <= ctl.clk_pin;
      low_r <= ready_busy_out ? '0 : low_r + 16'h1;
      if (ctl.clk_pin && !pin_r && ready_busy_out) begin
        if (ctl.action == ACT_CMD)
          cmd_r <= data_in;
        if (ctl.action == ACT_ADDR && ctl.bsel == BS_LOW)
          adr_r <= data_in;
      end
    end
  end
  assign flw = cmd_r == CMD_WR_FLASH || cmd_r == CMD_WR_EEP;
  assign wcmd = ctl.bsel == BS_LOW && (flw || cmd_r == CMD_WR_FUSE ||
    cmd_r == CMD_ERASE);
  assign sig = adr_r == 8'h00 ? SIG0 : adr_r == 8'h01 ? SIG1 :
    adr_r == 8'h02 ? SIG2 : 8'h00;
  sequence s_go;
    $fell(ctl.wr_n) && ready_busy_out && wcmd;
  endsequence
  sequence s_nop;
    $fell(ctl.wr_n) && ready_busy_out && cmd_r == CMD_NOP;
  endsequence
  sequence s_bad;
    $fell(ctl.wr_n) && ready_busy_out && flw && ctl.bsel != BS_LOW;
  endsequence
  a_write_busy: assert property (s_go |-> ##[2:3] !ready_busy_out)
    else $error("write did not start busy");
  a_nop_idle: assert property (s_nop |-> ready_busy_out [*4])
    else $error("write after no-op went busy");
  a_badsel_idle: assert property (s_bad |-> ready_busy_out [*4])
    else $error("write with wrong select went busy");
  a_busy_cause: assert property ($fell(ready_busy_out) |->
    $past(ctl.wr_n) == 1'b0) else $error("busy without strobe");
  a_busy_len: assert property ($rose(ready_busy_out) |->
    low_r >= WRITE_CYCLES - 1) else $error("busy too short");
  a_busy_ends: assert property (low_r <= ERASE_CYCLES + 4)
    else $error("busy too long");
  a_bus_release: assert property (ctl.oe_n [*2] |->
    bus.doe_n == 8'hff) else $error("bus not released");
  a_drive_oe: assert property (bus.doe_n != 8'hff |->
    !$past(ctl.oe_n)) else $error("bus driven without enable");
  a_sig_read: assert property ((cmd_r == CMD_RD_SIG &&
    !ctl.oe_n && ctl.bsel == BS_LOW) [*2] |-> bus.dout == sig)
    else $error("wrong signature byte");
endmodule : ppm_port_monitor
bind ppm_port ppm_port_monitor #(.WRITE_CYCLES(WRITE_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) ppm_port_monitor_i (.clk(clk),
  .reset_n(reset_n), .ctl(ctl), .data_in(data_in), .bus(bus),
  .ready_busy_out(ready_busy_out));

/* File: ppm_prog.sv */
`timescale 1ns/100ps
module ppm_prog (
  input wire logic clk,
  input wire logic ready_busy_out,
  input wire ppm_pkg::ppm_bus_t bus,
  output ppm_pkg::ppm_ctl_t ctl,
  output logic [7:0] data_out
);
  import ppm_pkg::*;
  initial begin
    ctl = '{2'h3, BS_LOW, 1'b0, 1'b0, 1'b1, 1'b1};
    data_out = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic load(input logic [1:0] a, input logic [1:0] s,
    input logic [7:0] d);
    ctl.action <= a;
    ctl.bsel <= s;
    data_out <= d;
    step(2);
    ctl.clk_pin <= 1'b1;
    step(2);
    ctl.clk_pin <= 1'b0;
    step(1);
    data_out <= ~d;
    step(1);
  endtask : load
  task automatic latch();
    ctl.bsel <= BS_HIGH;
    step(2);
    ctl.latch_pin <= 1'b1;
    step(2);
    ctl.latch_pin <= 1'b0;
    step(2);
  endtask : latch
  task automatic write(input logic [1:0] s, output logic busy);
    busy = 1'b0;
    ctl.bsel <= s;
    step(2);
    ctl.wr_n <= 1'b0;
    step(2);
    ctl.wr_n <= 1'b1;
    for (int i = 0; i < 40 && !(busy && ready_busy_out); i++) begin
      step(1);
      #1;
      if (!ready_busy_out)
        busy = 1'b1;
    end
    step(1);
    ctl.bsel <= BS_LOW;
    step(2);
  endtask : write
  task automatic read(input logic [1:0] s, output logic [7:0] v,
    output logic [7:0] drv, output logic [7:0] rel);
    ctl.oe_n <= 1'b0;
    ctl.bsel <= s;
    step(3);
    #1;
    v = bus.dout;
    drv = bus.doe_n;
    step(1);
    ctl.oe_n <= 1'b1;
    step(3);
    #1;
    rel = bus.doe_n;
    step(1);
  endtask : read
endmodule : ppm_prog

/* File: tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top;
  import ppm_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ppm_ctl_t ctl;
  ppm_bus_t bus;
  logic [7:0] prog_d;
  logic [7:0] wire_d;
  logic rdy;
  logic [7:0] v;
  logic [7:0] rel;
  logic [7:0] drv;
  logic b;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  assign wire_d = (bus.dout & ~bus.doe_n) | (prog_d & bus.doe_n);
  ppm_port #(.WRITE_CYCLES(5), .ERASE_CYCLES(8)) ppm_port_i (.clk(clk),
    .reset_n(reset_n), .ctl(ctl), .data_in(wire_d), .bus(bus),
    .ready_busy_out(rdy));
  ppm_prog ppm_prog_i (.clk(clk), .ready_busy_out(rdy), .bus(bus),
    .ctl(ctl), .data_out(prog_d));
  task automatic cmd(input logic [7:0] c);
    ppm_prog_i.load(ACT_CMD, BS_LOW, c);
  endtask : cmd
  task automatic adr(input logic [1:0] s, input logic [7:0] a);
    ppm_prog_i.load(ACT_ADDR, s, a);
  endtask : adr
  task automatic dat(input logic [1:0] s, input logic [7:0] d);
    ppm_prog_i.load(ACT_DATA, s, d);
  endtask : dat
  task automatic rd(input logic [1:0] s);
    ppm_prog_i.read(s, v, drv, rel);
    `CHK(drv, 8'h00)
    `CHK(rel, 8'hff)
  endtask : rd
  task automatic wr(input logic [1:0] s, input logic e);
    ppm_prog_i.write(s, b);
    `CHK(b, e)
  endtask : wr
  task automatic t_sig();
    logic [7:0] sg [3] = '{SIG0, SIG1, SIG2};
    cmd(CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      adr(BS_LOW, 8'(i));
      rd(BS_LOW);
      `CHK(v, sg[i])
    end
    ppm_prog_i.load(2'h3, BS_LOW, 8'h00);
    rd(BS_LOW);
    `CHK(v, SIG2)
    adr(BS_LOW, 8'h03);
    rd(BS_LOW);
    `CHK(v, 8'h00)
  endtask : t_sig
  task automatic t_flash();
    cmd(CMD_WR_FLASH);
    adr(BS_EXT, 8'h00);
    adr(BS_HIGH, 8'h01);
    adr(BS_LOW, 8'h3f);
    dat(BS_LOW, 8'h34);
    dat(BS_HIGH, 8'h12);
    ppm_prog_i.latch();
    adr(BS_LOW, 8'h00);
    dat(BS_LOW, 8'h78);
    dat(BS_HIGH, 8'h56);
    ppm_prog_i.latch();
    wr(BS_HIGH, 1'b0);
    wr(BS_LOW, 1'b1);
    cmd(CMD_NOP);
    wr(BS_LOW, 1'b0);
    cmd(CMD_RD_FLASH);
    adr(BS_LOW, 8'h3f);
    rd(BS_LOW);
    `CHK(v, 8'h34)
    rd(BS_HIGH);
    `CHK(v, 8'h12)
    adr(BS_LOW, 8'h00);
    rd(BS_HIGH);
    `CHK(v, 8'h56)
  endtask : t_flash
  task automatic t_eep();
    cmd(CMD_WR_EEP);
    adr(BS_HIGH, 8'h03);
    adr(BS_LOW, 8'hff);
    dat(BS_LOW, 8'ha5);
    ppm_prog_i.latch();
    wr(BS_LOW, 1'b1);
    cmd(CMD_RD_EEP);
    rd(BS_LOW);
    `CHK(v, 8'ha5)
  endtask : t_eep
  task automatic t_fuse();
    logic [7:0] fv [3] = '{8'he1, 8'hd2, 8'hb4};
    logic [1:0] ws [3] = '{BS_LOW, BS_HIGH, BS_EXT};
    logic [1:0] rs [3] = '{BS_LOW, BS_FHI, BS_EXT};
    cmd(CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      dat(BS_LOW, fv[i]);
      wr(ws[i], 1'b1);
    end
    cmd(CMD_RD_FUSE);
    for (int i = 0; i < 3; i++) begin
      rd(rs[i]);
      `CHK(v, fv[i])
    end
  endtask : t_fuse
  task automatic t_lock();
    cmd(CMD_WR_LOCK);
    dat(BS_LOW, 8'hfc);
    wr(BS_LOW, 1'b1);
    dat(BS_LOW, 8'hc3);
    wr(BS_LOW, 1'b1);
    cmd(CMD_RD_FUSE);
    rd(BS_HIGH);
    `CHK(v, 8'hfc)
  endtask : t_lock
  task automatic t_erase();
    cmd(CMD_ERASE);
    wr(BS_LOW, 1'b1);
    cmd(CMD_RD_FUSE);
    rd(BS_HIGH);
    `CHK(v, LOCK_RST)
    rd(BS_LOW);
    `CHK(v, 8'he1)
    cmd(CMD_RD_FLASH);
    adr(BS_HIGH, 8'h01);
    adr(BS_LOW, 8'h3f);
    rd(BS_LOW);
    `CHK(v, ERASED_BYTE)
  endtask : t_erase
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_sig();
    t_flash();
    t_eep();
    t_fuse();
    t_lock();
    t_erase();
    finish_test();
  end
endmodule : tb_top
